/* File: hw/pmsc_pkg.sv */
package pmsc_pkg;
  localparam int unsigned NUM_CH          = 4;
  // core clock rate and timing counts
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned RESET_MIN_US    = 10;   // reset_min_pulse, microseconds
  localparam int unsigned RESET_MIN_CYC   =
    (RESET_MIN_US * (CLK_HZ / 1_000_000) < 1) ? 1 : RESET_MIN_US * (CLK_HZ / 1_000_000);
  localparam int unsigned INIT_MS         = 500;  // init_time, milliseconds
  localparam int unsigned INIT_CYC        = INIT_MS * (CLK_HZ / 1000);
  // power control byte field positions and reset value
  localparam int unsigned PWR_OVERRIDE_BIT = 0;
  localparam int unsigned PWR_FORCE_LP_BIT = 1;
  localparam int unsigned PWR_UPPER_EN_BIT = 2;
  localparam logic [7:0]  PWR_CTRL_RST     = 8'h00;
  localparam logic [3:0]  MUTE_OFF_RST     = 4'h0;

  // allowed power range
  typedef enum logic [1:0] {
    PMSC_PWR_LOW   = 2'b00,  // class 1 only
    PMSC_PWR_MID   = 2'b01,  // classes 2 to 4, under 3.5 W
    PMSC_PWR_HIGH  = 2'b10   // classes 2 to 7
  } pmsc_pwr_e;

  typedef enum logic [1:0] {
    PMSC_ST_RESET = 2'b00,
    PMSC_ST_INIT  = 2'b01,
    PMSC_ST_DONE  = 2'b10,
    PMSC_ST_RUN   = 2'b11
  } pmsc_state_e;

  // two-wire link events handed to the core
  typedef struct packed {
    logic read_ready_byte;   // status byte holding init_pending_flag read
    logic read_flag_field;   // flag field read
  } pmsc_twi_ev_s;

  // per-channel squelch controls
  typedef struct packed {
    logic [NUM_CH-1:0] rx_mute_off;
    logic [NUM_CH-1:0] tx_mute_off;
  } pmsc_mute_s;
endpackage : pmsc_pkg

/* File: hw/pmsc_core.sv */
// Functional notes
// - while select is high, ignore two-wire traffic and never acknowledge
// - select input biased high inside the module
// - reset pulled up; low beyond minimum pulse restores every default
// - init time starts at rising edge ending the reset pulse
// - completion shown by attention low with init_pending_flag cleared
// - completion also posted after power-up without a reset pulse
// - low power pin pulled up; high means low power mode
// - power limit from pin and byte 93 bits 0, 1, 2
// - presence output tied to ground
// - attention low flags fault or critical status
// - attention is open collector, pull low only
// - attention released after ready byte read zero and flag field read
// - channel signal loss squelches its receive output
// - receive mute on by default, host may disable it
// - weak transmit input mutes optical output and sets absent flag
// - transmit mute on by default, host may disable it
// - override bit selects force bit over pin for power mode
// - upper class enable resets low; clear limits to classes 2 to 4
module pmsc_core #(
  parameter int unsigned RESET_MIN_CYCLES = pmsc_pkg::RESET_MIN_CYC,
  parameter int unsigned INIT_CYCLES      = pmsc_pkg::INIT_CYC
) (
  input  wire logic                          core_clk,
  input  wire logic                          rst_b,
  input  wire logic                          twi_clk,
  input  wire logic                          twi_rst_b,
  input  wire logic                          module_select_n,
  input  wire logic                          select_pin_driven,
  input  wire logic                          module_reset_n,
  input  wire logic                          reset_pin_driven,
  input  wire logic                          low_power_pin,
  input  wire logic                          low_power_pin_driven,
  input  wire logic                          twi_addr_match,
  output logic                               twi_ack_allow,
  input  wire pmsc_pkg::pmsc_twi_ev_s        twi_ev,
  input  wire logic                          pwr_ctrl_wr,
  input  wire logic [7:0]                    pwr_ctrl_wdata,
  input  wire logic                          mute_wr,
  input  wire pmsc_pkg::pmsc_mute_s          mute_wdata,
  input  wire logic                          fault_event,
  input  wire logic [pmsc_pkg::NUM_CH-1:0]   rx_signal_absent,
  input  wire logic [pmsc_pkg::NUM_CH-1:0]   tx_input_weak,
  output logic                               init_pending_flag,
  output logic [pmsc_pkg::NUM_CH-1:0]        signal_absent_flag,
  output logic [pmsc_pkg::NUM_CH-1:0]        tx_input_absent_flag,
  output logic [pmsc_pkg::NUM_CH-1:0]        rx_squelch,
  output logic [pmsc_pkg::NUM_CH-1:0]        tx_squelch,
  output logic [7:0]                         pwr_ctrl,
  output pmsc_pkg::pmsc_pwr_e                pwr_mode,
  output logic                               presence_n_o,
  output logic                               presence_n_oe,
  output logic                               attention_n_o,
  output logic                               attention_n_oe
);

  // link domain, clocked by the two-wire clock
  // select bias: undriven pin reads high
  logic sel_level;
  assign sel_level = select_pin_driven ? module_select_n : 1'b1;

  // select brought onto the link clock before it gates any flop
  logic sel_sync1_reg;
  logic sel_sync2_reg;
  always_ff @(posedge twi_clk or negedge twi_rst_b) begin
    if (!twi_rst_b) begin
      sel_sync1_reg <= 1'b1;
      sel_sync2_reg <= 1'b1;
    end else begin
      sel_sync1_reg <= sel_level;
      sel_sync2_reg <= sel_sync1_reg;
    end
  end

  // select gate of the acknowledge, combinational from the unsynchronised pin level
  always_comb begin
    twi_ack_allow = twi_addr_match & ~sel_level;
  end

  // toggles carry link events, writes into the core domain
  logic       rd_ready_tgl_reg;
  logic       rd_flag_tgl_reg;
  logic       pwr_tgl_reg;
  logic       mute_tgl_reg;
  logic [7:0] pwr_hold_reg;
  pmsc_pkg::pmsc_mute_s mute_hold_reg;

  always_ff @(posedge twi_clk or negedge twi_rst_b) begin
    if (!twi_rst_b) begin
      rd_ready_tgl_reg <= 1'b0;
      rd_flag_tgl_reg  <= 1'b0;
    end else if (!sel_sync2_reg) begin
      if (twi_ev.read_ready_byte) rd_ready_tgl_reg <= ~rd_ready_tgl_reg;
      if (twi_ev.read_flag_field) rd_flag_tgl_reg  <= ~rd_flag_tgl_reg;
    end
  end

  // write holding words, stable until the core picks them up
  always_ff @(posedge twi_clk or negedge twi_rst_b) begin
    if (!twi_rst_b) begin
      pwr_tgl_reg   <= 1'b0;
      mute_tgl_reg  <= 1'b0;
      pwr_hold_reg  <= pmsc_pkg::PWR_CTRL_RST;
      mute_hold_reg <= '{rx_mute_off: pmsc_pkg::MUTE_OFF_RST, tx_mute_off: pmsc_pkg::MUTE_OFF_RST};
    end else if (!sel_sync2_reg) begin
      if (pwr_ctrl_wr) begin
        pwr_hold_reg <= pwr_ctrl_wdata;
        pwr_tgl_reg  <= ~pwr_tgl_reg;
      end
      if (mute_wr) begin
        mute_hold_reg <= mute_wdata;
        mute_tgl_reg  <= ~mute_tgl_reg;
      end
    end
  end

  // core domain
  // pin synchronisers, toggles included
  localparam int unsigned NSYNC = 6 + 2 * pmsc_pkg::NUM_CH;
  logic [NSYNC-1:0] sync_in;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  logic [NSYNC-1:0] sync3_reg;
  logic             rst_pin_lvl;
  logic             lp_pin_lvl;
  assign rst_pin_lvl = reset_pin_driven ? module_reset_n : 1'b1;
  assign lp_pin_lvl  = low_power_pin_driven ? low_power_pin : 1'b1;
  assign sync_in = {tx_input_weak, rx_signal_absent, rd_ready_tgl_reg, rd_flag_tgl_reg,
                    pwr_tgl_reg, mute_tgl_reg, rst_pin_lvl, lp_pin_lvl};

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_reg <= {{(NSYNC-2){1'b0}}, 2'b11};  // reset and power pins start idle high
      sync2_reg <= {{(NSYNC-2){1'b0}}, 2'b11};
      sync3_reg <= {{(NSYNC-2){1'b0}}, 2'b11};
    end else begin
      sync1_reg <= sync_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  logic rst_lvl;
  logic lp_lvl;
  logic ev_ready_rd;
  logic ev_flag_rd;
  logic ev_pwr_wr;
  logic ev_mute_wr;
  logic [pmsc_pkg::NUM_CH-1:0] rx_loss;
  logic [pmsc_pkg::NUM_CH-1:0] tx_weak;
  assign lp_lvl      = sync2_reg[0];
  assign rst_lvl     = sync2_reg[1];
  assign ev_mute_wr  = sync2_reg[2] ^ sync3_reg[2];
  assign ev_pwr_wr   = sync2_reg[3] ^ sync3_reg[3];
  assign ev_flag_rd  = sync2_reg[4] ^ sync3_reg[4];
  assign ev_ready_rd = sync2_reg[5] ^ sync3_reg[5];
  assign rx_loss     = sync2_reg[6 +: pmsc_pkg::NUM_CH];
  assign tx_weak     = sync2_reg[6 + pmsc_pkg::NUM_CH +: pmsc_pkg::NUM_CH];

  // reset pulse width counter, rst_long marks a valid pulse
  logic [31:0] rst_cnt_reg;
  logic        rst_long;
  assign rst_long = (rst_cnt_reg >= RESET_MIN_CYCLES);
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_cnt_reg <= 32'h0000_0000;
    end else if (rst_lvl) begin
      rst_cnt_reg <= 32'h0000_0000;
    end else if (!rst_long) begin
      rst_cnt_reg <= rst_cnt_reg + 32'h0000_0001;
    end
  end

  // soft reset held while a long low pulse is on the pin
  logic soft_rst;
  assign soft_rst = rst_long & ~rst_lvl;

  // init sequencer: power-up enters init directly
  pmsc_pkg::pmsc_state_e state_reg;
  logic [31:0]           init_cnt_reg;
  logic                  rd_ready_seen_reg;
  logic                  rd_flag_seen_reg;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg    <= pmsc_pkg::PMSC_ST_INIT;
      init_cnt_reg <= 32'h0000_0000;
    end else if (soft_rst) begin
      state_reg    <= pmsc_pkg::PMSC_ST_RESET;
      init_cnt_reg <= 32'h0000_0000;
    end else begin
      case (state_reg)
        pmsc_pkg::PMSC_ST_RESET: begin
          state_reg <= pmsc_pkg::PMSC_ST_INIT;
        end
        pmsc_pkg::PMSC_ST_INIT: begin
          if (init_cnt_reg >= INIT_CYCLES - 1) state_reg <= pmsc_pkg::PMSC_ST_DONE;
          init_cnt_reg <= init_cnt_reg + 32'h0000_0001;
        end
        pmsc_pkg::PMSC_ST_DONE: begin
          if (rd_ready_seen_reg && rd_flag_seen_reg) state_reg <= pmsc_pkg::PMSC_ST_RUN;
        end
        default: begin
          state_reg <= pmsc_pkg::PMSC_ST_RUN;
        end
      endcase
    end
  end

  // reads of ready byte and flag field after completion
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_ready_seen_reg <= 1'b0;
      rd_flag_seen_reg  <= 1'b0;
    end else if (state_reg != pmsc_pkg::PMSC_ST_DONE) begin
      rd_ready_seen_reg <= 1'b0;
      rd_flag_seen_reg  <= 1'b0;
    end else begin
      if (ev_ready_rd) rd_ready_seen_reg <= 1'b1;
      if (ev_flag_rd)  rd_flag_seen_reg  <= 1'b1;
    end
  end

  // sticky fault, set wins over clear by flag field read
  logic fault_reg;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fault_reg <= 1'b0;
    end else if (soft_rst) begin
      fault_reg <= 1'b0;
    end else if (fault_event) begin
      fault_reg <= 1'b1;
    end else if (ev_flag_rd) begin
      fault_reg <= 1'b0;
    end
  end

  // attention held low until released, never pulsed
  logic att_low_reg;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      att_low_reg <= 1'b0;
    end else begin
      att_low_reg <= (state_reg == pmsc_pkg::PMSC_ST_DONE) | fault_reg;
    end
  end

  // init pending reads set until completion
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      init_pending_flag <= 1'b1;
    end else begin
      init_pending_flag <= (state_reg == pmsc_pkg::PMSC_ST_RESET) |
                           (state_reg == pmsc_pkg::PMSC_ST_INIT);
    end
  end

  // user settings, restored to defaults by a module reset
  logic [pmsc_pkg::NUM_CH-1:0] rx_mute_off_reg;
  logic [pmsc_pkg::NUM_CH-1:0] tx_mute_off_reg;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pwr_ctrl        <= pmsc_pkg::PWR_CTRL_RST;
      rx_mute_off_reg <= pmsc_pkg::MUTE_OFF_RST;
      tx_mute_off_reg <= pmsc_pkg::MUTE_OFF_RST;
    end else if (soft_rst) begin
      pwr_ctrl        <= pmsc_pkg::PWR_CTRL_RST;
      rx_mute_off_reg <= pmsc_pkg::MUTE_OFF_RST;
      tx_mute_off_reg <= pmsc_pkg::MUTE_OFF_RST;
    end else begin
      if (ev_pwr_wr) pwr_ctrl <= {5'h00, pwr_hold_reg[2:0]};  // reserved bits read zero
      if (ev_mute_wr) begin
        rx_mute_off_reg <= mute_hold_reg.rx_mute_off;
        tx_mute_off_reg <= mute_hold_reg.tx_mute_off;
      end
    end
  end

  // power mode truth table
  logic lp_req;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pwr_mode <= pmsc_pkg::PMSC_PWR_LOW;
    end else begin
      if (lp_req) pwr_mode <= pmsc_pkg::PMSC_PWR_LOW;
      else if (pwr_ctrl[pmsc_pkg::PWR_UPPER_EN_BIT]) pwr_mode <= pmsc_pkg::PMSC_PWR_HIGH;
      else pwr_mode <= pmsc_pkg::PMSC_PWR_MID;
    end
  end
  assign lp_req = pwr_ctrl[pmsc_pkg::PWR_OVERRIDE_BIT] ?
                  pwr_ctrl[pmsc_pkg::PWR_FORCE_LP_BIT] : lp_lvl;

  // per-channel squelch and loss flags
  for (genvar ch = 0; ch < pmsc_pkg::NUM_CH; ch++) begin : g_ch
    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        signal_absent_flag[ch]   <= 1'b0;
        tx_input_absent_flag[ch] <= 1'b0;
        rx_squelch[ch]           <= 1'b0;
        tx_squelch[ch]           <= 1'b0;
      end else begin
        signal_absent_flag[ch]   <= rx_loss[ch];
        tx_input_absent_flag[ch] <= tx_weak[ch];
        rx_squelch[ch]           <= rx_loss[ch] & ~rx_mute_off_reg[ch];
        tx_squelch[ch]           <= tx_weak[ch] & ~tx_mute_off_reg[ch];
      end
    end
  end

  // open-collector pins: enable low while driving low
  assign presence_n_o   = 1'b0;
  assign presence_n_oe  = 1'b0;
  assign attention_n_o  = 1'b0;
  assign attention_n_oe = ~att_low_reg;

endmodule // pmsc_core

/* File: bench/pmsc_core_monitor.sv */
module pmsc_core_chk #(
  parameter int unsigned RESET_MIN_CYCLES = pmsc_pkg::RESET_MIN_CYC
) (
  input wire logic                core_clk,
  input wire logic                rst_b,
  input wire logic                module_select_n,
  input wire logic                select_pin_driven,
  input wire logic                module_reset_n,
  input wire logic                reset_pin_driven,
  input wire logic                low_power_pin,
  input wire logic                low_power_pin_driven,
  input wire logic                twi_addr_match,
  input wire logic                twi_ack_allow,
  input wire logic [3:0]          rx_signal_absent,
  input wire logic [3:0]          tx_input_weak,
  input wire logic                init_pending_flag,
  input wire logic [3:0]          signal_absent_flag,
  input wire logic [3:0]          tx_input_absent_flag,
  input wire logic [7:0]          pwr_ctrl,
  input wire pmsc_pkg::pmsc_pwr_e pwr_mode,
  input wire logic                presence_n_o,
  input wire logic                presence_n_oe,
  input wire logic                attention_n_o,
  input wire logic                attention_n_oe
);
  logic [31:0] rcnt;
  logic        lp_req;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // cycles the reset pin has been held low
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) rcnt <= 32'h0000_0000;
    else if (module_reset_n || !reset_pin_driven) rcnt <= 32'h0000_0000;
    else if (rcnt != 32'hffff_ffff) rcnt <= rcnt + 32'h0000_0001;
  end
  // low power request after override selection
  assign lp_req = pwr_ctrl[0] ? pwr_ctrl[1] : (low_power_pin | !low_power_pin_driven);
  sequence init_done; $fell(init_pending_flag); endsequence
  sequence attn_held; !attention_n_oe [*3]; endsequence
  ack_blocked_a: assert property (
    (module_select_n || !select_pin_driven) |-> !twi_ack_allow) else $error("ack while idle");
  ack_given_a: assert property (
    (!module_select_n && select_pin_driven && twi_addr_match) |-> twi_ack_allow)
    else $error("no ack while selected");
  presence_tied_a: assert property (!presence_n_o && !presence_n_oe)
    else $error("presence not driven low");
  attn_pull_a: assert property (!attention_n_o) else $error("attention drives high");
  ready_attn_a: assert property (init_done |-> ##[0:2] attn_held)
    else $error("no held attention at init done");
  pin_reset_a: assert property (rcnt == RESET_MIN_CYCLES + 5 |->
    init_pending_flag && pwr_ctrl == 8'h00) else $error("long reset pulse ignored");
  rsvd_zero_a: assert property (pwr_ctrl[7:3] == 5'h00) else $error("reserved bits set");
  rx_flag_a: assert property (
    $stable(rx_signal_absent)[*4] |-> signal_absent_flag == rx_signal_absent)
    else $error("signal loss flag wrong");
  tx_flag_a: assert property (
    $stable(tx_input_weak)[*4] |-> tx_input_absent_flag == tx_input_weak)
    else $error("tx absent flag wrong");
  pwr_mode_a: assert property (
    (!init_pending_flag && $stable({pwr_ctrl, lp_req}))[*4]
    |-> pwr_mode == (lp_req ? 2'b00 : {pwr_ctrl[2], !pwr_ctrl[2]})) else $error("bad mode");
endmodule // pmsc_core_chk

bind pmsc_core pmsc_core_chk #(.RESET_MIN_CYCLES(RESET_MIN_CYCLES)) chk (
  .core_clk, .rst_b, .module_select_n, .select_pin_driven, .module_reset_n,
  .reset_pin_driven, .low_power_pin, .low_power_pin_driven, .twi_addr_match,
  .twi_ack_allow, .rx_signal_absent, .tx_input_weak, .init_pending_flag,
  .signal_absent_flag, .tx_input_absent_flag, .pwr_ctrl, .pwr_mode, .presence_n_o,
  .presence_n_oe, .attention_n_o, .attention_n_oe
);

/* File: bench/pmsc_host_model.sv */
module pmsc_host_model (
  input  wire logic attention_n_o,
  input  wire logic attention_n_oe,
  input  wire logic presence_n_o,
  input  wire logic presence_n_oe,
  output logic      attention_n,
  output logic      presence_n
);
  // host pull-ups on both open-collector status lines
  assign attention_n = attention_n_oe ? 1'b1 : attention_n_o;
  assign presence_n  = presence_n_oe ? 1'b1 : presence_n_o;
endmodule // pmsc_host_model

/* File: bench/pmsc_core_test.sv */
module pmsc_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned RMIN  = 4;
  localparam int unsigned INITC = 20;
  logic core_clk = 1'b0, twi_clk = 1'b0, rst_b, module_select_n, select_pin_driven;
  logic module_reset_n, reset_pin_driven, low_power_pin, low_power_pin_driven, twi_addr_match;
  logic pwr_ctrl_wr, mute_wr, fault_event, twi_ack_allow, init_pending_flag, presence_n_o;
  logic presence_n_oe, attention_n_o, attention_n_oe, attention_n, presence_n;
  logic [7:0]             pwr_ctrl_wdata, pwr_ctrl, d, m;
  logic [3:0]             rx_signal_absent, tx_input_weak, signal_absent_flag;
  logic [3:0]             tx_input_absent_flag, rx_squelch, tx_squelch;
  pmsc_pkg::pmsc_twi_ev_s twi_ev;
  pmsc_pkg::pmsc_mute_s   mute_wdata;
  pmsc_pkg::pmsc_pwr_e    pwr_mode;
  int                     failures = 0, samples_checked = 0, cycles = 0, n;
  integer                 seed = 32'h38dc;
  pmsc_core #(.RESET_MIN_CYCLES(RMIN), .INIT_CYCLES(INITC)) uut (
    .core_clk, .rst_b, .twi_clk, .twi_rst_b(rst_b), .module_select_n, .select_pin_driven,
    .module_reset_n, .reset_pin_driven, .low_power_pin, .low_power_pin_driven,
    .twi_addr_match, .twi_ack_allow, .twi_ev, .pwr_ctrl_wr, .pwr_ctrl_wdata, .mute_wr,
    .mute_wdata, .fault_event, .rx_signal_absent, .tx_input_weak, .init_pending_flag,
    .signal_absent_flag, .tx_input_absent_flag, .rx_squelch, .tx_squelch, .pwr_ctrl,
    .pwr_mode, .presence_n_o, .presence_n_oe, .attention_n_o, .attention_n_oe
  );
  pmsc_host_model host (
    .attention_n_o, .attention_n_oe, .presence_n_o, .presence_n_oe, .attention_n, .presence_n
  );
  // core clock and an unrelated link clock
  initial forever #10 core_clk = ~core_clk;
  initial #3 forever #7.5 twi_clk = ~twi_clk;
  // hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      conclude();
    end
  end
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    if (failures == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic idle(input int k);
    repeat (k) @(negedge core_clk);
  endtask
  // one-cycle link read events, then settle
  task automatic ev(input logic rdy, input logic flg);
    @(negedge twi_clk);
    twi_ev = {rdy, flg};
    @(negedge twi_clk);
    twi_ev = '0;
    idle(8);
  endtask
  // link write of power control or mute word
  task automatic wr(input logic pw, input logic [7:0] v);
    @(negedge twi_clk);
    pwr_ctrl_wdata = v;
    mute_wdata = v;
    pwr_ctrl_wr = pw;
    mute_wr = !pw;
    @(negedge twi_clk);
    pwr_ctrl_wr = 1'b0;
    mute_wr = 1'b0;
    idle(8);
  endtask
  task automatic wait_ready(output int k);
    k = 0;
    while (init_pending_flag !== 1'b0 && k < 200) begin
      @(negedge core_clk);
      k++;
    end
  endtask
  function automatic logic [7:0] exp_mode(logic [7:0] c, logic p, logic dr);
    if (c[0] ? c[1] : (p || !dr)) return {6'h00, pmsc_pkg::PMSC_PWR_LOW};
    return {6'h00, c[2] ? pmsc_pkg::PMSC_PWR_HIGH : pmsc_pkg::PMSC_PWR_MID};
  endfunction
  // main sequence
  initial begin
    {rst_b, module_select_n, twi_addr_match, pwr_ctrl_wr, mute_wr, fault_event} = '0;
    {select_pin_driven, module_reset_n, reset_pin_driven} = 3'b111;
    {low_power_pin, low_power_pin_driven, d, m} = {2'b11, 16'h0000};
    {pwr_ctrl_wdata, rx_signal_absent, tx_input_weak, twi_ev, mute_wdata} = '0;
    idle(2);
    rst_b = 1'b1;
    cmp("init_pending", 8'h01, init_pending_flag);
    cmp("pwr_ctrl", 8'h00, pwr_ctrl);
    cmp("presence", 8'h00, presence_n);
    wait_ready(n);
    idle(3);
    cmp("attention", 8'h00, attention_n);
    cmp("pwr_mode_boot", {6'h00, pmsc_pkg::PMSC_PWR_LOW}, pwr_mode);
    twi_addr_match = 1'b1;
    module_select_n = 1'b1;
    idle(2);
    cmp("ack_deselected", 8'h00, twi_ack_allow);
    {module_select_n, select_pin_driven} = 2'b00;
    idle(2);
    cmp("ack_floating", 8'h00, twi_ack_allow);
    // select first, address only after the assert time
    {select_pin_driven, twi_addr_match} = 2'b10;
    idle(4);
    twi_addr_match = 1'b1;
    idle(1);
    cmp("ack_selected", 8'h01, twi_ack_allow);
    {twi_addr_match, module_select_n} = 2'b01;
    idle(4);
    ev(1'b1, 1'b1);
    cmp("attention_idle", 8'h00, attention_n);
    module_select_n = 1'b0;
    idle(4);
    ev(1'b1, 1'b0);
    cmp("attention_half", 8'h00, attention_n);
    ev(1'b0, 1'b1);
    cmp("attention_clear", 8'h01, attention_n);
    idle(1);
    fault_event = 1'b1;
    idle(1);
    fault_event = 1'b0;
    idle(6);
    cmp("attention_fault", 8'h00, attention_n);
    ev(1'b0, 1'b1);
    cmp("attention_fclr", 8'h01, attention_n);
    // all override codes first, then random power words, with random pin levels throughout
    for (int i = 0; i < 16; i++) begin
      d = (i < 8) ? i[7:0] : 8'($random(seed));
      {low_power_pin, low_power_pin_driven} = 2'($random(seed));
      wr(1'b1, d);
      cmp("pwr_ctrl", {5'h00, d[2:0]}, pwr_ctrl);
      cmp("pwr_mode", exp_mode(d, low_power_pin, low_power_pin_driven), pwr_mode);
    end
    module_select_n = 1'b1;
    idle(4);
    wr(1'b1, ~d);
    cmp("pwr_ctrl_idle", {5'h00, d[2:0]}, pwr_ctrl);
    module_select_n = 1'b0;
    idle(4);
    // default squelch, then random mute overrides
    for (int i = 0; i < 8; i++) begin
      {rx_signal_absent, tx_input_weak} = 8'($random(seed));
      m = (i < 4) ? 8'h00 : 8'($random(seed));
      if (i < 4) idle(8);
      else wr(1'b0, m);
      idle(6);
      cmp("rx_flag", rx_signal_absent, signal_absent_flag);
      cmp("tx_flag", tx_input_weak, tx_input_absent_flag);
      cmp("rx_squelch", rx_signal_absent & ~m[7:4], rx_squelch);
      cmp("tx_squelch", tx_input_weak & ~m[3:0], tx_squelch);
    end
    // known settings so that a module reset visibly restores defaults
    wr(1'b1, 8'h05);
    module_reset_n = 1'b0;
    idle(2);
    module_reset_n = 1'b1;
    idle(6);
    cmp("short_reset", 8'h00, init_pending_flag);
    cmp("pwr_ctrl_kept", 8'h05, pwr_ctrl);
    module_reset_n = 1'b0;
    idle(12);
    cmp("long_reset", 8'h01, init_pending_flag);
    cmp("pwr_ctrl_dflt", 8'h00, pwr_ctrl);
    cmp("rx_squelch_dflt", rx_signal_absent, rx_squelch);
    cmp("tx_squelch_dflt", tx_input_weak, tx_squelch);
    module_reset_n = 1'b1;
    wait_ready(n);
    cmp("init_time", 8'h01, 8'(n >= INITC && n <= INITC + 6));
    idle(3);
    cmp("attention_rst", 8'h00, attention_n);
    conclude();
  end
endmodule // pmsc_core_test
